// [cgr_defines.vh]
`ifndef CGR_DEFINES_VH
`define CGR_DEFINES_VH

// serial word layout
`define CGR_WORD_W          32
`define CGR_ADDR_FIELD      4:0
`define CGR_ADDR_W          5

// register addresses
`define CGR_ADDR_CTRL0      5'h00
`define CGR_ADDR_OSC_BUF    5'h0A
`define CGR_ADDR_SYNC       5'h0B
`define CGR_ADDR_LOCK_PIN   5'h0C
`define CGR_ADDR_LOOP_FILT  5'h18
`define CGR_ADDR_PUMP_LD    5'h1A
`define CGR_ADDR_REF_DIV    5'h1C
`define CGR_ADDR_FB_CAL     5'h1D
`define CGR_ADDR_FB_DIV     5'h1E
`define CGR_ADDR_WLOCK      5'h1F
`define CGR_ADDR_LAST_LOCK  5'h1E

// field positions
`define CGR_F_SOFT_RESET    17
`define CGR_F_OSC_B_AMP     31:30
`define CGR_F_OSC_A_FMT     27:24
`define CGR_F_OSC_B_EN      23
`define CGR_F_OSC_A_EN      22
`define CGR_F_OSC_B_DIVSEL  21
`define CGR_F_OSC_A_DIVSEL  20
`define CGR_F_OSC_DIV       18:16
`define CGR_F_SYNC_EXCL     25:20
`define CGR_F_SYNC_POL      16
`define CGR_F_SYNC_KIND     13:12
`define CGR_F_XTAL_EN       5
`define CGR_F_LD_SRC        31:27
`define CGR_F_LD_KIND       26:24
`define CGR_F_HOLD_SYNC     23
`define CGR_F_CAP_SECOND    31:28
`define CGR_F_CAP_FIRST     27:24
`define CGR_F_RES_SECOND    22:20
`define CGR_F_RES_FIRST     18:16
`define CGR_F_REF_DBL       29
`define CGR_F_CP_GAIN       27:26
`define CGR_F_LD_COUNT      19:6
`define CGR_F_REF_DIV       31:20
`define CGR_F_FB_CAL        22:5
`define CGR_F_PRESCALE      26:24
`define CGR_F_FB_DIV        22:5
`define CGR_F_WLOCK         5

// reset values
`define CGR_RST_OSC_B_AMP   2'h2
`define CGR_RST_OSC_A_FMT   4'h1
`define CGR_RST_OSC_B_EN    1'h0
`define CGR_RST_OSC_A_EN    1'h1
`define CGR_RST_OSC_B_DIVSEL 1'h0
`define CGR_RST_OSC_A_DIVSEL 1'h0
`define CGR_RST_OSC_DIV     3'h0
`define CGR_RST_SYNC_EXCL   6'h18
`define CGR_RST_SYNC_POL    1'h1
`define CGR_RST_SYNC_KIND   2'h1
`define CGR_RST_XTAL_EN     1'h0
`define CGR_RST_LD_SRC      5'h03
`define CGR_RST_LD_KIND     3'h3
`define CGR_RST_HOLD_SYNC   1'h0
`define CGR_RST_LOOP_CAP    4'h0
`define CGR_RST_LOOP_RES    3'h0
`define CGR_RST_REF_DBL     1'h0
`define CGR_RST_CP_GAIN     2'h3
`define CGR_RST_LD_COUNT    14'h2000
`define CGR_RST_REF_DIV     12'h004
`define CGR_RST_FB_CAL      18'h00030
`define CGR_RST_PRESCALE    3'h2
`define CGR_RST_FB_DIV      18'h00030
`define CGR_RST_WLOCK       1'h0

`endif

// [cgr_sync2.v]
// two-stage synchroniser for asynchronous pins
module cgr_sync2 #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             mclk,
  input  wire             rstn,
  // asynchronous in, synchronised out
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // first stage feeds only the second
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// [cgr_config_regs.v]
// Function
// R1 - buffer A format 1, buffer B amplitude 2
// R2 - buffer B enable bit, resets disabled
// R3 - buffer A enable bit, resets enabled
// R4 - buffer B divider select, resets bypass
// R5 - buffer A bypass default, shared divider 0
// R6 - six sync exclude bits, groups 3,4 set
// R7 - sync polarity 1, toggle syncs, kind 1
// R8 - crystal oscillator enable, resets off
// R9 - lock pin source 3, kind 3
// R10 - hold sync asserted until lock
// R11 - lock after count in-window detector cycles
// R12 - reference divider field, resets to 4
// R13 - host mirrors feedback divider into cal copy
// R14 - prescaler field 2 to 8, resets 2
// R15 - feedback divider field, resets 48
// R16 - reference doubler bit, resets off
// R17 - charge pump gain resets to 3
// R18 - loop capacitor fields reset to 0
// R19 - loop resistor fields reset to 0
// R20 - soft reset reloads all defaults
// R21 - soft reset acts on latch falling edge
// R22 - write lock bit blocks registers 0-30
// R23 - fields hold until rewritten or reset
`include "cgr_defines.vh"

module cgr_config_regs #(
  parameter LD_COUNT_W = 14
) (
  // clock and reset
  input  wire        mclk,
  input  wire        rstn,
  // serial programming pins
  input  wire        ser_clk,
  input  wire        ser_data,
  input  wire        latch_enable_pin,
  // phase detector status, same clock domain
  input  wire        phase_detector_rate,
  input  wire        phase_in_window,
  // oscillator buffer control
  output reg  [1:0]  osc_buf_b_amplitude,
  output reg  [3:0]  osc_buf_a_format,
  output reg         osc_buf_b_enable,
  output reg         osc_buf_a_enable,
  output reg         osc_buf_b_div_select,
  output reg         osc_buf_a_div_select,
  output reg  [2:0]  osc_shared_divider,
  // synchronisation control
  output reg  [5:0]  sync_exclude,
  output reg         sync_pin_polarity,
  output reg  [1:0]  sync_pin_kind,
  output reg         crystal_osc_enable,
  output reg         sync_request,
  // lock pin control
  output reg  [4:0]  lock_pin_source,
  output reg  [2:0]  lock_pin_kind,
  output reg         hold_sync_until_lock,
  // loop filter
  output reg  [3:0]  loop_cap_second,
  output reg  [3:0]  loop_cap_first,
  output reg  [2:0]  loop_res_second,
  output reg  [2:0]  loop_res_first,
  // charge pump and lock detect
  output reg         reference_doubler_enable,
  output reg  [1:0]  charge_pump_gain,
  output reg  [13:0] lock_detect_count,
  output reg         digital_lock_detect,
  // dividers
  output reg  [11:0] reference_divider,
  output reg  [17:0] feedback_cal_copy,
  output reg  [2:0]  feedback_prescaler,
  output reg  [17:0] feedback_divider,
  // write lock
  output reg         config_write_lock
);

  wire [2:0]             pins_sync;
  reg                    sclk_d;
  reg                    le_d;
  reg  [`CGR_WORD_W-1:0] shift_word;
  reg                    reset_armed;
  reg  [LD_COUNT_W-1:0]  ld_counter;
  reg                    sync_pol_d;

  // bring serial pins into the mclk domain
  cgr_sync2 #(
    .WIDTH (3)
  ) u_pin_sync (
    .mclk     (mclk),
    .rstn     (rstn),
    .async_in ({latch_enable_pin, ser_data, ser_clk}),
    .sync_out (pins_sync)
  );

  // edges of synchronised clock and latch enable
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sclk_d <= 1'b0;
      le_d   <= 1'b0;
    end
    else
    begin
      sclk_d <= pins_sync[0];
      le_d   <= pins_sync[2];
    end
  end

  wire                   sclk_rise = pins_sync[0] & ~sclk_d;
  wire                   le_rise   = pins_sync[2] & ~le_d;
  wire                   le_fall   = ~pins_sync[2] & le_d;

  // shift data in msb first while latch enable is low
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      shift_word <= {`CGR_WORD_W{1'b0}};
    else if (sclk_rise && !pins_sync[2])
      shift_word <= {shift_word[`CGR_WORD_W-2:0], pins_sync[1]};
  end

  // address decode at the latch rising edge
  wire [`CGR_ADDR_W-1:0] word_addr  = shift_word[`CGR_ADDR_FIELD];
  // writes to 0..30 blocked while locked; lock register always open
  wire                   write_open = le_rise && !config_write_lock; // R22
  wire                   wr_osc     = write_open && (word_addr == `CGR_ADDR_OSC_BUF);
  wire                   wr_sync    = write_open && (word_addr == `CGR_ADDR_SYNC);
  wire                   wr_ldpin   = write_open && (word_addr == `CGR_ADDR_LOCK_PIN);
  wire                   wr_loop    = write_open && (word_addr == `CGR_ADDR_LOOP_FILT);
  wire                   wr_pump    = write_open && (word_addr == `CGR_ADDR_PUMP_LD);
  wire                   wr_ref     = write_open && (word_addr == `CGR_ADDR_REF_DIV);
  wire                   wr_cal     = write_open && (word_addr == `CGR_ADDR_FB_CAL);
  wire                   wr_fb      = write_open && (word_addr == `CGR_ADDR_FB_DIV);
  wire                   wr_wlock   = le_rise && (word_addr == `CGR_ADDR_WLOCK);

  // arm soft reset on a register 0 write with reset set; other writes disarm
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      reset_armed <= 1'b0;
    else if (write_open)
      reset_armed <= (word_addr == `CGR_ADDR_CTRL0) &&
                     shift_word[`CGR_F_SOFT_RESET]; // R20
    else if (le_fall)
      reset_armed <= 1'b0;
  end

  // reload happens on the falling latch edge that ends the reset word
  wire                   soft_reload = le_fall && reset_armed; // R21

  // oscillator buffer control register
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      osc_buf_b_amplitude  <= `CGR_RST_OSC_B_AMP;
      osc_buf_a_format     <= `CGR_RST_OSC_A_FMT;
      osc_buf_b_enable     <= `CGR_RST_OSC_B_EN;
      osc_buf_a_enable     <= `CGR_RST_OSC_A_EN;
      osc_buf_b_div_select <= `CGR_RST_OSC_B_DIVSEL;
      osc_buf_a_div_select <= `CGR_RST_OSC_A_DIVSEL;
      osc_shared_divider   <= `CGR_RST_OSC_DIV;
    end
    else if (soft_reload)
    begin
      osc_buf_b_amplitude  <= `CGR_RST_OSC_B_AMP; // R1
      osc_buf_a_format     <= `CGR_RST_OSC_A_FMT; // R1
      osc_buf_b_enable     <= `CGR_RST_OSC_B_EN; // R2
      osc_buf_a_enable     <= `CGR_RST_OSC_A_EN; // R3
      osc_buf_b_div_select <= `CGR_RST_OSC_B_DIVSEL; // R4
      osc_buf_a_div_select <= `CGR_RST_OSC_A_DIVSEL; // R5
      osc_shared_divider   <= `CGR_RST_OSC_DIV; // R5
    end
    else if (wr_osc)
    begin
      osc_buf_b_amplitude  <= shift_word[`CGR_F_OSC_B_AMP]; // R1
      osc_buf_a_format     <= shift_word[`CGR_F_OSC_A_FMT]; // R1
      osc_buf_b_enable     <= shift_word[`CGR_F_OSC_B_EN]; // R2
      osc_buf_a_enable     <= shift_word[`CGR_F_OSC_A_EN]; // R3
      osc_buf_b_div_select <= shift_word[`CGR_F_OSC_B_DIVSEL]; // R4
      osc_buf_a_div_select <= shift_word[`CGR_F_OSC_A_DIVSEL]; // R5
      osc_shared_divider   <= shift_word[`CGR_F_OSC_DIV]; // R5
    end
  end

  // synchronisation control register
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync_exclude       <= `CGR_RST_SYNC_EXCL;
      sync_pin_polarity  <= `CGR_RST_SYNC_POL;
      sync_pin_kind      <= `CGR_RST_SYNC_KIND;
      crystal_osc_enable <= `CGR_RST_XTAL_EN;
    end
    else if (soft_reload)
    begin
      sync_exclude       <= `CGR_RST_SYNC_EXCL; // R6
      sync_pin_polarity  <= `CGR_RST_SYNC_POL; // R7
      sync_pin_kind      <= `CGR_RST_SYNC_KIND; // R7
      crystal_osc_enable <= `CGR_RST_XTAL_EN; // R8
    end
    else if (wr_sync)
    begin
      sync_exclude       <= shift_word[`CGR_F_SYNC_EXCL]; // R6
      sync_pin_polarity  <= shift_word[`CGR_F_SYNC_POL]; // R7
      sync_pin_kind      <= shift_word[`CGR_F_SYNC_KIND]; // R7
      crystal_osc_enable <= shift_word[`CGR_F_XTAL_EN]; // R8
    end
  end

  // lock pin control register
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      lock_pin_source      <= `CGR_RST_LD_SRC;
      lock_pin_kind        <= `CGR_RST_LD_KIND;
      hold_sync_until_lock <= `CGR_RST_HOLD_SYNC;
    end
    else if (soft_reload)
    begin
      lock_pin_source      <= `CGR_RST_LD_SRC; // R9
      lock_pin_kind        <= `CGR_RST_LD_KIND; // R9
      hold_sync_until_lock <= `CGR_RST_HOLD_SYNC; // R10
    end
    else if (wr_ldpin)
    begin
      lock_pin_source      <= shift_word[`CGR_F_LD_SRC]; // R9
      lock_pin_kind        <= shift_word[`CGR_F_LD_KIND]; // R9
      hold_sync_until_lock <= shift_word[`CGR_F_HOLD_SYNC]; // R10
    end
  end

  // loop filter register
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      loop_cap_second <= `CGR_RST_LOOP_CAP;
      loop_cap_first  <= `CGR_RST_LOOP_CAP;
      loop_res_second <= `CGR_RST_LOOP_RES;
      loop_res_first  <= `CGR_RST_LOOP_RES;
    end
    else if (soft_reload)
    begin
      loop_cap_second <= `CGR_RST_LOOP_CAP; // R18
      loop_cap_first  <= `CGR_RST_LOOP_CAP; // R18
      loop_res_second <= `CGR_RST_LOOP_RES; // R19
      loop_res_first  <= `CGR_RST_LOOP_RES; // R19
    end
    else if (wr_loop)
    begin
      loop_cap_second <= shift_word[`CGR_F_CAP_SECOND]; // R18
      loop_cap_first  <= shift_word[`CGR_F_CAP_FIRST]; // R18
      loop_res_second <= shift_word[`CGR_F_RES_SECOND]; // R19
      loop_res_first  <= shift_word[`CGR_F_RES_FIRST]; // R19
    end
  end

  // charge pump and lock detect settings register
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      reference_doubler_enable <= `CGR_RST_REF_DBL;
      charge_pump_gain         <= `CGR_RST_CP_GAIN;
      lock_detect_count        <= `CGR_RST_LD_COUNT;
    end
    else if (soft_reload)
    begin
      reference_doubler_enable <= `CGR_RST_REF_DBL; // R16
      charge_pump_gain         <= `CGR_RST_CP_GAIN; // R17
      lock_detect_count        <= `CGR_RST_LD_COUNT; // R11
    end
    else if (wr_pump)
    begin
      reference_doubler_enable <= shift_word[`CGR_F_REF_DBL]; // R16
      charge_pump_gain         <= shift_word[`CGR_F_CP_GAIN]; // R17
      lock_detect_count        <= shift_word[`CGR_F_LD_COUNT]; // R11
    end
  end

  // divider registers; field holds its value until rewritten
  always @(posedge mclk or negedge rstn) // R23
  begin
    if (!rstn)
    begin
      reference_divider  <= `CGR_RST_REF_DIV;
      feedback_cal_copy  <= `CGR_RST_FB_CAL;
      feedback_prescaler <= `CGR_RST_PRESCALE;
      feedback_divider   <= `CGR_RST_FB_DIV;
    end
    else if (soft_reload)
    begin
      reference_divider  <= `CGR_RST_REF_DIV; // R12
      feedback_cal_copy  <= `CGR_RST_FB_CAL;
      feedback_prescaler <= `CGR_RST_PRESCALE; // R14
      feedback_divider   <= `CGR_RST_FB_DIV; // R15
    end
    else
    begin
      if (wr_ref)
        reference_divider <= shift_word[`CGR_F_REF_DIV]; // R12
      if (wr_cal)
        feedback_cal_copy <= shift_word[`CGR_F_FB_CAL]; // R13
      if (wr_fb)
      begin
        feedback_prescaler <= shift_word[`CGR_F_PRESCALE]; // R14
        feedback_divider   <= shift_word[`CGR_F_FB_DIV]; // R15
      end
    end
  end

  // write lock register, itself always writable
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      config_write_lock <= `CGR_RST_WLOCK;
    else if (soft_reload)
      config_write_lock <= `CGR_RST_WLOCK; // R20
    else if (wr_wlock)
      config_write_lock <= shift_word[`CGR_F_WLOCK]; // R22
  end

  // lock detect: count in-window detector cycles, any miss restarts
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ld_counter          <= {LD_COUNT_W{1'b0}};
      digital_lock_detect <= 1'b0;
    end
    else if (!phase_in_window)
    begin
      ld_counter          <= {LD_COUNT_W{1'b0}}; // R11
      digital_lock_detect <= 1'b0; // R11
    end
    else if (phase_detector_rate && !digital_lock_detect)
    begin
      if ((ld_counter + 1'b1) >= lock_detect_count)
        digital_lock_detect <= 1'b1; // R11
      else
        ld_counter <= ld_counter + 1'b1;
    end
  end

  // sync request: pulse on polarity toggle, held high while waiting for lock
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync_pol_d   <= `CGR_RST_SYNC_POL;
      sync_request <= 1'b0;
    end
    else
    begin
      sync_pol_d   <= sync_pin_polarity;
      sync_request <= (sync_pol_d != sync_pin_polarity) | // R7
                      (hold_sync_until_lock & ~digital_lock_detect); // R10
    end
  end

endmodule

// [cgr_config_regs_props.sv]
module cgr_config_regs_props #(
  parameter LD_COUNT_W = 14
) (
  // clock and reset
  input wire        mclk,
  input wire        rstn,
  // pins
  input wire        latch_enable_pin,
  input wire        phase_detector_rate,
  input wire        phase_in_window,
  // watched outputs
  input wire        sync_pin_polarity,
  input wire        sync_request,
  input wire        hold_sync_until_lock,
  input wire [13:0] lock_detect_count,
  input wire        digital_lock_detect,
  input wire [11:0] reference_divider,
  input wire [17:0] feedback_divider,
  input wire [3:0]  osc_buf_a_format,
  input wire        config_write_lock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [LD_COUNT_W:0] pd_cnt;
  logic [3:0]          since_le;
  logic                le_q;
  wire                 hold_cause = hold_sync_until_lock && !digital_lock_detect;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // in-window detector pulses, and cycles since the latch pin last moved
  always @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      pd_cnt <= '0;
      since_le <= 4'h0;
      le_q <= 1'h0;
    end
    else
    begin
      pd_cnt <= !phase_in_window ? '0 : pd_cnt + phase_detector_rate;
      since_le <= (latch_enable_pin != le_q) ? 4'h0 : since_le + (since_le != 4'hF);
      le_q <= latch_enable_pin;
    end

  lock_rise_count_a: assert property (
    $rose(digital_lock_detect) |-> (pd_cnt >= lock_detect_count) && (pd_cnt != 0))
    else $error("lock detect rose before the pulse count was reached");
  lock_rise_late_a: assert property (
    (phase_in_window && pd_cnt >= lock_detect_count && pd_cnt != 0) |-> digital_lock_detect)
    else $error("lock detect missing after the pulse count was reached");
  lock_needs_window_a: assert property (
    digital_lock_detect |-> $past(phase_in_window))
    else $error("lock detect high without the phase window");
  sync_hold_on_a: assert property (
    hold_cause |=> sync_request)
    else $error("sync request not held while waiting for lock");
  sync_cause_a: assert property (
    sync_request |-> $past(hold_cause)
      || ($past(sync_pin_polarity, 1) != $past(sync_pin_polarity, 2))
      || ($past(sync_pin_polarity, 2) != $past(sync_pin_polarity, 3)))
    else $error("sync request without a cause");
  polarity_sync_a: assert property (
    $changed(sync_pin_polarity) |-> ##[1:3] sync_request)
    else $error("polarity toggle gave no sync request");
  field_settle_a: assert property (
    ($changed(reference_divider) || $changed(feedback_divider) || $changed(osc_buf_a_format))
      |-> since_le <= 4'h7)
    else $error("field changed without a latch pin event");
  wlock_hold_a: assert property (
    ($past(config_write_lock) && config_write_lock)
      |-> $stable(reference_divider) && $stable(feedback_divider) && $stable(osc_buf_a_format))
    else $error("field changed while writes are locked");

  cover property ($rose(digital_lock_detect));
  cover property ($rose(config_write_lock));
  cover property ($changed(sync_pin_polarity));
endmodule

bind cgr_config_regs cgr_config_regs_props #(.LD_COUNT_W(LD_COUNT_W)) chk (.*);

// [cgr_host_model.sv]
module cgr_host_model (
  // clock
  input  wire  mclk,
  // serial programming pins
  output logic ser_clk,
  output logic ser_data,
  output logic latch_enable_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // pins idle: latch and clock low
  initial
  begin
    ser_clk = 1'h0;
    ser_data = 1'h0;
    latch_enable_pin = 1'h0;
  end

  // one word msb first, every level held at least four cycles; stay keeps the latch high
  task automatic send(input logic [31:0] w, input bit stay);
    for (int i = 31; i >= 0; i--)
    begin
      @(negedge mclk);
      ser_data = w[i];
      repeat (4) @(negedge mclk);
      ser_clk = 1'h1;
      repeat (4) @(negedge mclk);
      ser_clk = 1'h0;
    end
    repeat (4) @(negedge mclk);
    latch_enable_pin = 1'h1;
    ser_data = ~ser_data; // data no longer valid, show no stale bit
    repeat (4) @(negedge mclk);
    if (!stay)
      drop();
  endtask

  // lower the latch pin and let it settle
  task automatic drop();
    latch_enable_pin = 1'h0;
    repeat (4) @(negedge mclk);
  endtask
endmodule

// [tb_clock_gen_pll_config_regs.sv]
module tb_clock_gen_pll_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct { logic [5:0] sel; logic [31:0] exp; } cgr_note_t;
  logic        mclk, rstn, phase_detector_rate, phase_in_window;
  wire         ser_clk, ser_data, latch_enable_pin;
  wire  [1:0]  osc_buf_b_amplitude, sync_pin_kind, charge_pump_gain;
  wire  [3:0]  osc_buf_a_format, loop_cap_second, loop_cap_first;
  wire  [2:0]  osc_shared_divider, lock_pin_kind, loop_res_second, loop_res_first;
  wire  [2:0]  feedback_prescaler;
  wire  [5:0]  sync_exclude;
  wire  [4:0]  lock_pin_source;
  wire  [13:0] lock_detect_count;
  wire  [11:0] reference_divider;
  wire  [17:0] feedback_cal_copy, feedback_divider;
  wire         osc_buf_b_enable, osc_buf_a_enable, osc_buf_b_div_select, osc_buf_a_div_select;
  wire         crystal_osc_enable, sync_pin_polarity, sync_request, hold_sync_until_lock;
  wire         reference_doubler_enable, digital_lock_detect, config_write_lock;
  logic [5:0]  ad [9] = '{6'h0A, 6'h0B, 6'h0C, 6'h18, 6'h1A, 6'h1C, 6'h1D, 6'h1E, 6'h1F};
  logic [31:0] msk [9] = '{32'hCFF7_0000, 32'h03F1_3020, 32'hFF80_0000, 32'hFF77_0000,
    32'h2C0F_FFC0, 32'hFFF0_0000, 32'h007F_FFE0, 32'h077F_FFE0, 32'h0000_0020};
  logic [31:0] dft [9] = '{32'h8140_0000, 32'h0181_1000, 32'h1B00_0000, 32'h0000_0000,
    32'h0C08_0000, 32'h0040_0000, 32'h0000_0600, 32'h0200_0600, 32'h0000_0000};
  logic [31:0] cur [9];
  logic [31:0] r, w;
  logic [17:0] n;
  cgr_note_t   q [$];
  event        chk_ev;
  int          bad_count, checks_done, cycles;

  cgr_config_regs #(.LD_COUNT_W(14)) dut (.*);
  cgr_host_model host (.*);

  // clock and hang guard
  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], 1'h0} ^ (x[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
  endfunction

  // rebuild a register image from the field outputs
  function automatic logic [31:0] obs(input logic [5:0] s);
    case (s)
      6'h0A: obs = {osc_buf_b_amplitude, 2'h0, osc_buf_a_format, osc_buf_b_enable,
        osc_buf_a_enable, osc_buf_b_div_select, osc_buf_a_div_select, 1'h0,
        osc_shared_divider, 16'h0};
      6'h0B: obs = {6'h0, sync_exclude, 3'h0, sync_pin_polarity, 2'h0, sync_pin_kind,
        6'h0, crystal_osc_enable, 5'h0};
      6'h0C: obs = {lock_pin_source, lock_pin_kind, hold_sync_until_lock, 23'h0};
      6'h18: obs = {loop_cap_second, loop_cap_first, 1'h0, loop_res_second, 1'h0,
        loop_res_first, 16'h0};
      6'h1A: obs = {2'h0, reference_doubler_enable, 1'h0, charge_pump_gain, 6'h0,
        lock_detect_count, 6'h0};
      6'h1C: obs = {reference_divider, 20'h0};
      6'h1D: obs = {9'h0, feedback_cal_copy, 5'h0};
      6'h1E: obs = {5'h0, feedback_prescaler, 1'h0, feedback_divider, 5'h0};
      6'h1F: obs = {26'h0, config_write_lock, 5'h0};
      6'h20: obs = {31'h0, digital_lock_detect};
      default: obs = {31'h0, sync_request};
    endcase
  endfunction

  // every queued note, oldest first, against what the outputs show now
  initial
    forever
    begin
      @(chk_ev);
      while (q.size() > 0)
      begin
        checks_done++;
        if (obs(q[0].sel) !== q[0].exp)
        begin
          bad_count++;
          $display("MISMATCH image %h expected %h seen %h", q[0].sel, q[0].exp, obs(q[0].sel));
        end
        void'(q.pop_front());
      end
    end

  task automatic note(input logic [5:0] s, input logic [31:0] e);
    q.push_back('{s, e});
    ->chk_ev;
  endtask

  task automatic chk_all();
    repeat (2) @(negedge mclk);
    for (int i = 0; i < 9; i++)
      note(ad[i], cur[i]);
  endtask

  task automatic wr(input int i, input logic [31:0] v);
    host.send(v, 1'b0);
    cur[i] = v & msk[i];
    chk_all();
  endtask

  task automatic pulse();
    @(negedge mclk);
    phase_detector_rate = 1'h1;
    @(negedge mclk);
    phase_detector_rate = 1'h0;
    @(negedge mclk);
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // main sequence
  initial
  begin
    mclk = 1'h0;
    rstn = 1'h0;
    phase_detector_rate = 1'h0;
    phase_in_window = 1'h0;
    cur = dft;
    r = lfsr(32'h5C10E251);
    n = r[22:5];
    repeat (20) @(negedge mclk);
    rstn = 1'h1;
    chk_all();
    for (int i = 0; i < 8; i++)
    begin
      r = lfsr(r);
      w = {r[31:5], ad[i][4:0]};
      if (i >= 6)
        w[22:5] = n;
      wr(i, w);
    end
    host.send({r[31:5], 5'h13}, 1'b0);
    chk_all();
    wr(8, 32'h0000_003F);
    host.send({lfsr(r) & 32'hFFFF_FFE0} | 32'h0000_001C, 1'b0);
    chk_all();
    host.send(32'h0002_0000, 1'b0);
    chk_all();
    wr(8, 32'h0000_001F);
    host.send(32'hFFFF_FFE0, 1'b1);
    chk_all();
    host.drop();
    cur = dft;
    chk_all();
    host.send(32'h0000_000B, 1'b1);
    note(6'h21, 32'h1);
    @(negedge mclk);
    note(6'h21, 32'h0);
    host.drop();
    cur[1] = 32'h0000_0000;
    wr(4, 32'h0000_00DA);
    wr(2, 32'h0080_000C);
    note(6'h21, 32'h1);
    phase_in_window = 1'h1;
    pulse();
    pulse();
    note(6'h20, 32'h0);
    pulse();
    note(6'h20, 32'h1);
    repeat (3) @(negedge mclk);
    note(6'h21, 32'h0);
    phase_in_window = 1'h0;
    repeat (3) @(negedge mclk);
    note(6'h20, 32'h0);
    note(6'h21, 32'h1);
    @(negedge mclk);
    end_of_test();
  end
endmodule
